// ---- logic/pin_logic_pkg.sv ----
// Shared constants, register map and carriers for the channel pin logic
package pin_logic_pkg;

	// Channel and FIFO geometry
	localparam int CHANNELS = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int COUNT_W = 5;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// Register offsets on the three address lines
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_DMA = 3'h2;
	localparam logic [2:0] ADDR_AFR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_EVENTS = 3'h5;

	// Field positions
	localparam int MCR_IRQ_EN_BIT = 3;
	localparam int AFR_SEL_LSB = 1;
	localparam int DMA_MODE_BIT = 0;
	localparam int DMA_TRIG_LSB = 1;
	localparam int EV_RX_READY = 0;
	localparam int EV_TX_READY = 1;
	localparam int EV_LINE = 2;
	localparam int EV_W = 3;
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_TX_SPACE = 1;
	localparam int ST_RX_TRIG = 2;

	// Reset values
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] DMA_RESET = 8'h00;
	localparam logic [7:0] AFR_RESET = 8'h00;
	localparam logic [7:0] MCR_RESET = 8'h00;
	localparam logic [2:0] EVENTS_RESET = 3'h0;

	// Receive trigger levels selected by the two DMA trigger bits
	localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
	localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
	localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
	localparam logic [4:0] TRIG_LEVEL_3 = 5'h0E;

	// Default multi-function select codes; the fourth code is reserved
	localparam logic [1:0] MF_CODE_IRQ_EN = 2'h0;
	localparam logic [1:0] MF_CODE_BAUD = 2'h1;
	localparam logic [1:0] MF_CODE_RX_READY = 2'h2;

	// Pin inputs synchronised: strobes, selects, address, data
	localparam int SYNC_W = 4 + ADDR_W + DATA_W;
	localparam logic [14:0] SYNC_RESET = 15'h7800;

	// Live state of one channel from the core logic
	typedef struct packed {
		logic [COUNT_W-1:0] rx_count;
		logic [COUNT_W-1:0] tx_count;
		logic baud16;
		logic line_event;
	} chan_stat_s;

	// Configuration of one channel taken from its registers
	typedef struct packed {
		logic [1:0] mf_sel;
		logic irq_pin_en;
		logic dma_mode;
		logic [COUNT_W-1:0] rx_trigger;
	} chan_cfg_s;

	// Registered pin levels of one channel
	typedef struct packed {
		logic mf;
		logic rx_ready_n;
		logic tx_ready_n;
	} chan_pins_s;

endpackage

// ---- logic/chan_pins.sv ----
// Per-channel multi-function, receive-ready and transmit-ready pin logic
`timescale 1ns/100ps
module chan_pins #(
	parameter logic [1:0] CODE_IRQ_EN = pin_logic_pkg::MF_CODE_IRQ_EN,
	parameter logic [1:0] CODE_BAUD = pin_logic_pkg::MF_CODE_BAUD,
	parameter logic [1:0] CODE_RX_READY = pin_logic_pkg::MF_CODE_RX_READY,
	parameter int DEPTH = pin_logic_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Channel configuration and state
	input wire pin_logic_pkg::chan_cfg_s cfg,
	input wire pin_logic_pkg::chan_stat_s stat,
	// Registered pins and one-cycle ready events
	output pin_logic_pkg::chan_pins_s pins_q,
	output logic rx_ready_rise_q,
	output logic tx_ready_rise_q
);

	logic rx_ready;
	logic tx_ready;
	logic mf_d;

	// Data waiting; mode 0 needs one character
	// Mode 1 stays high below the trigger level
	always_comb begin
		if (cfg.dma_mode)
			rx_ready = (stat.rx_count >= cfg.rx_trigger) &&
				(stat.rx_count != '0);
		else
			rx_ready = (stat.rx_count != '0);
	end

	// Ready while one location is free
	assign tx_ready = (stat.tx_count < DEPTH[pin_logic_pkg::COUNT_W-1:0]);

	// Select what drives the pin; codes are parameters
	always_comb begin
		if (cfg.mf_sel == CODE_IRQ_EN)
			mf_d = !cfg.irq_pin_en;
		else if (cfg.mf_sel == CODE_BAUD)
			mf_d = stat.baud16;
		else if (cfg.mf_sel == CODE_RX_READY)
			mf_d = !rx_ready;
		else
			mf_d = 1'b1; // Reserved code idles high
	end

	// Pins registered; indicator high after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			pins_q.mf <= 1'b1;
			pins_q.rx_ready_n <= 1'b1;
			pins_q.tx_ready_n <= 1'b1;
		end else begin
			pins_q.mf <= mf_d;
			pins_q.rx_ready_n <= !rx_ready;
			pins_q.tx_ready_n <= !tx_ready;
		end
	end

	// Pulse when a ready output becomes active
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_ready_rise_q <= 1'b0;
			tx_ready_rise_q <= 1'b0;
		end else begin
			rx_ready_rise_q <= rx_ready && pins_q.rx_ready_n;
			tx_ready_rise_q <= tx_ready && pins_q.tx_ready_n;
		end
	end

endmodule

// ---- logic/uart_status_pins.sv ----
// Top of the dual-channel status pin logic with its strobe register port
//
// Function
// - Each channel has its own multi-function pin following only its state.
// - Two alternate-function bits choose what the multi-function pin drives.
// - Indicator is high while the interrupt pin enable bit is clear, low when it is set.
// - Indicator presents high after reset.
// - Baud selection drives the sixteen-times baud clock onto the pin.
// - Receive-ready goes low while received characters are waiting.
// - Receive-ready is high when empty or below trigger level.
// - Receive-ready also serves single-character transfers in DMA mode 0.
// - Each channel has an active-low transmit-ready output.
// - Transmit-ready low while a location is free, high when full.
// - Reset high returns all registers and outputs to reset state.
// - Serial transmitter and receiver are held disabled during reset.
// - Read strobe falling puts the addressed register on the data bus.
// - Write strobe falling copies the data bus into the addressed register.
// - Interrupt pin driven only with enable bit, INTERRUPT_ENABLE_REG enable and condition.
`timescale 1ns/100ps
module uart_status_pins #(
	parameter logic [1:0] CODE_IRQ_EN = pin_logic_pkg::MF_CODE_IRQ_EN,
	parameter logic [1:0] CODE_BAUD = pin_logic_pkg::MF_CODE_BAUD,
	parameter logic [1:0] CODE_RX_READY = pin_logic_pkg::MF_CODE_RX_READY,
	parameter int DEPTH = pin_logic_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Parallel bus pins from the CPU or DMA controller
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Channel state from the core logic
	input wire pin_logic_pkg::chan_stat_s stat_a,
	input wire pin_logic_pkg::chan_stat_s stat_b,
	// Channel A pins
	output logic multi_function_out_a,
	output logic receive_ready_a_n,
	output logic transmit_ready_a_n,
	output logic channel_a_interrupt,
	output logic channel_a_interrupt_oe,
	output logic serial_enable_a,
	// Channel B pins
	output logic multi_function_out_b,
	output logic receive_ready_b_n,
	output logic transmit_ready_b_n,
	output logic channel_b_interrupt,
	output logic channel_b_interrupt_oe,
	output logic serial_enable_b
);

	// Channel count and width of the synchronised pin bundle
	localparam int NCH = pin_logic_pkg::CHANNELS;
	localparam int SW = pin_logic_pkg::SYNC_W;

	// Trigger code to level, used by every channel
	function automatic logic [4:0] trigger_level(input logic [1:0] code);
		case (code)
			2'h0: trigger_level = pin_logic_pkg::TRIG_LEVEL_0;
			2'h1: trigger_level = pin_logic_pkg::TRIG_LEVEL_1;
			2'h2: trigger_level = pin_logic_pkg::TRIG_LEVEL_2;
			default: trigger_level = pin_logic_pkg::TRIG_LEVEL_3;
		endcase
	endfunction

	logic [SW-1:0] pin_raw;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic rd_n_s;
	logic wr_n_s;
	logic rd_n_prev_q;
	logic wr_n_prev_q;
	logic rd_fall;
	logic wr_fall;
	logic [NCH-1:0] sel_s;
	logic [2:0] addr_s;
	logic [7:0] wdata_s;

	logic [7:0] ier_q [NCH];
	logic [7:0] dma_q [NCH];
	logic [7:0] afr_q [NCH];
	logic [7:0] mcr_q [NCH];
	logic [2:0] events_q [NCH];
	logic [2:0] events_d [NCH];
	logic [NCH-1:0] irq_q;
	logic [NCH-1:0] irq_oe_q;
	logic [NCH-1:0] serial_en_q;
	logic [NCH-1:0] rd_ch;

	pin_logic_pkg::chan_stat_s stat [NCH];
	pin_logic_pkg::chan_cfg_s cfg [NCH];
	pin_logic_pkg::chan_pins_s pins [NCH];
	logic [NCH-1:0] rx_rise;
	logic [NCH-1:0] tx_rise;
	logic [7:0] rdata;
	logic [7:0] data_out_q;
	logic data_oe_q;

	assign stat[0] = stat_a;
	assign stat[1] = stat_b;

	// Bus pins arrive from outside the clock domain
	assign pin_raw = {read_strobe_n, write_strobe_n, chip_select_b_n,
		chip_select_a_n, addr, data_in};

	// Two-stage synchroniser on every bus pin
	// Reset level idles strobes and selects, so no false edge on release
	genvar gs;
	generate
		for (gs = 0; gs < SW; gs++) begin : g_sync
			always_ff @(posedge clk) begin
				if (reset) begin
					sync1_q[gs] <= pin_logic_pkg::SYNC_RESET[gs];
					sync2_q[gs] <= pin_logic_pkg::SYNC_RESET[gs];
				end else begin
					sync1_q[gs] <= pin_raw[gs];
					sync2_q[gs] <= sync1_q[gs];
				end
			end
		end
	endgenerate

	assign rd_n_s = sync2_q[SW-1];
	assign wr_n_s = sync2_q[SW-2];
	assign sel_s = ~sync2_q[SW-3:SW-4];
	assign addr_s = sync2_q[10:8];
	assign wdata_s = sync2_q[7:0];

	// Previous strobe levels for falling-edge detection
	// Only the second stage is read; the first may still be settling
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_n_prev_q <= 1'b1;
			wr_n_prev_q <= 1'b1;
		end else begin
			rd_n_prev_q <= rd_n_s;
			wr_n_prev_q <= wr_n_s;
		end
	end

	assign rd_fall = rd_n_prev_q && !rd_n_s;
	assign wr_fall = wr_n_prev_q && !wr_n_s;

	// Channel A wins a read when both selects are low
	// One byte fits on the bus, so a read needs a single winner
	assign rd_ch = sel_s[0] ? 2'b01 : {sel_s[1], 1'b0};

	genvar gc;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_ch
			// Write strobe falling loads the addressed register
			// Both channels may be written at once when both selected
			always_ff @(posedge clk) begin
				if (reset) begin
					ier_q[gc] <= pin_logic_pkg::IER_RESET;
					dma_q[gc] <= pin_logic_pkg::DMA_RESET;
					afr_q[gc] <= pin_logic_pkg::AFR_RESET;
					mcr_q[gc] <= pin_logic_pkg::MCR_RESET;
				end else if (wr_fall && sel_s[gc]) begin
					case (addr_s)
						pin_logic_pkg::ADDR_IER: ier_q[gc] <= wdata_s;
						pin_logic_pkg::ADDR_DMA: dma_q[gc] <= wdata_s;
						pin_logic_pkg::ADDR_AFR: afr_q[gc] <= wdata_s;
						pin_logic_pkg::ADDR_MCR: mcr_q[gc] <= wdata_s;
						default: ;
					endcase
				end
			end

			// Configuration taken only from this channel
			assign cfg[gc].mf_sel =
				afr_q[gc][pin_logic_pkg::AFR_SEL_LSB +: 2];
			assign cfg[gc].irq_pin_en =
				mcr_q[gc][pin_logic_pkg::MCR_IRQ_EN_BIT];
			assign cfg[gc].dma_mode =
				dma_q[gc][pin_logic_pkg::DMA_MODE_BIT];
			assign cfg[gc].rx_trigger =
				trigger_level(dma_q[gc][pin_logic_pkg::DMA_TRIG_LSB +: 2]);

			chan_pins #(
				.CODE_IRQ_EN(CODE_IRQ_EN),
				.CODE_BAUD(CODE_BAUD),
				.CODE_RX_READY(CODE_RX_READY),
				.DEPTH(DEPTH)
			) u_pins (
				.clk(clk),
				.reset(reset),
				.cfg(cfg[gc]),
				.stat(stat[gc]),
				.pins_q(pins[gc]),
				.rx_ready_rise_q(rx_rise[gc]),
				.tx_ready_rise_q(tx_rise[gc])
			);

			// Sticky events; a set in the clearing cycle survives
			// Masked events still stick, so unmasking later raises the pin
			always_comb begin
				events_d[gc] = events_q[gc];
				if (rd_fall && rd_ch[gc] &&
					addr_s == pin_logic_pkg::ADDR_EVENTS)
					events_d[gc] = '0;
				if (rx_rise[gc])
					events_d[gc][pin_logic_pkg::EV_RX_READY] = 1'b1;
				if (tx_rise[gc])
					events_d[gc][pin_logic_pkg::EV_TX_READY] = 1'b1;
				if (stat[gc].line_event)
					events_d[gc][pin_logic_pkg::EV_LINE] = 1'b1;
			end

			// Sticky event register of this channel
			always_ff @(posedge clk) begin
				if (reset)
					events_q[gc] <= pin_logic_pkg::EVENTS_RESET;
				else
					events_q[gc] <= events_d[gc];
			end

			// Driven only with enable bit, INTERRUPT_ENABLE_REG and a condition
			// The level stays high while an unmasked event is set
			// Level is reported even while the pin itself is tri-stated
			always_ff @(posedge clk) begin
				if (reset) begin
					irq_q[gc] <= 1'b0;
					irq_oe_q[gc] <= 1'b0;
				end else begin
					irq_q[gc] <= |(events_q[gc] & ier_q[gc][2:0]);
					irq_oe_q[gc] <= cfg[gc].irq_pin_en &&
						(|(events_q[gc] & ier_q[gc][2:0]));
				end
			end

			// Serial transmitter and receiver off in reset
			// Core logic gates its serial pins with this enable
			always_ff @(posedge clk) begin
				if (reset)
					serial_en_q[gc] <= 1'b0;
				else
					serial_en_q[gc] <= 1'b1;
			end
		end
	endgenerate

	// Register read mux for the selected channel
	// Reserved offsets read back as zero
	always_comb begin
		int ch;
		ch = rd_ch[1] ? 1 : 0;
		rdata = 8'h00;
		case (addr_s)
			pin_logic_pkg::ADDR_STATUS: begin
				rdata[pin_logic_pkg::ST_RX_AVAIL] = !pins[ch].rx_ready_n;
				rdata[pin_logic_pkg::ST_TX_SPACE] = !pins[ch].tx_ready_n;
				rdata[pin_logic_pkg::ST_RX_TRIG] =
					stat[ch].rx_count >= cfg[ch].rx_trigger;
			end
			pin_logic_pkg::ADDR_IER: rdata = ier_q[ch];
			pin_logic_pkg::ADDR_DMA: rdata = dma_q[ch];
			pin_logic_pkg::ADDR_AFR: rdata = afr_q[ch];
			pin_logic_pkg::ADDR_MCR: rdata = mcr_q[ch];
			pin_logic_pkg::ADDR_EVENTS: rdata = {5'h00, events_q[ch]};
			default: rdata = 8'h00;
		endcase
	end

	// Read strobe falling latches the addressed register
	// Bus is driven until the strobe returns high
	// Captured value holds after release for a slow host
	always_ff @(posedge clk) begin
		if (reset) begin
			data_out_q <= 8'h00;
			data_oe_q <= 1'b0;
		end else if (rd_fall && (|rd_ch)) begin
			data_out_q <= rdata;
			data_oe_q <= 1'b1;
		end else if (rd_n_s) begin
			data_oe_q <= 1'b0;
		end
	end

	// Outputs, each straight from a flip-flop
	assign data_out = data_out_q;
	assign data_oe = data_oe_q;
	assign multi_function_out_a = pins[0].mf;
	assign receive_ready_a_n = pins[0].rx_ready_n;
	assign transmit_ready_a_n = pins[0].tx_ready_n;
	assign channel_a_interrupt = irq_q[0];
	assign channel_a_interrupt_oe = irq_oe_q[0];
	assign serial_enable_a = serial_en_q[0];
	assign multi_function_out_b = pins[1].mf;
	assign receive_ready_b_n = pins[1].rx_ready_n;
	assign transmit_ready_b_n = pins[1].tx_ready_n;
	assign channel_b_interrupt = irq_q[1];
	assign channel_b_interrupt_oe = irq_oe_q[1];
	assign serial_enable_b = serial_en_q[1];

endmodule

// ---- verif/uart_status_pins_chk.sv ----
// Assertion checker for the dual-channel status pin logic
`timescale 1ns/100ps
module uart_status_pins_chk #(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bus side
	input wire logic read_strobe_n,
	input wire logic data_oe,
	// Channel state and pins
	input wire pin_logic_pkg::chan_stat_s stat_a,
	input wire pin_logic_pkg::chan_stat_s stat_b,
	input wire logic multi_function_out_a,
	input wire logic receive_ready_a_n,
	input wire logic transmit_ready_a_n,
	input wire logic transmit_ready_b_n,
	input wire logic channel_a_interrupt,
	input wire logic channel_a_interrupt_oe,
	input wire logic serial_enable_a
);
	default clocking @(posedge clk); endclocking

	// Reset parks outputs; reset itself is the antecedent here
	a_reset_outputs: assert property (
		reset |=> !data_oe && !channel_a_interrupt && receive_ready_a_n
		&& transmit_ready_a_n && !channel_a_interrupt_oe)
		else $error("outputs not parked in reset");
	a_serial_off: assert property (
		reset |=> !serial_enable_a)
		else $error("serial path enabled in reset");
	a_mf_default: assert property (
		reset |=> multi_function_out_a)
		else $error("multi-function pin low after reset");

	// Ready pins lag the core counts by one cycle
	a_tx_full_a: assert property (disable iff (reset)
		!$past(reset) |->
		transmit_ready_a_n == ($past(stat_a.tx_count) >= DEPTH))
		else $error("tx ready a wrong for fill level");
	a_tx_full_b: assert property (disable iff (reset)
		!$past(reset) |->
		transmit_ready_b_n == ($past(stat_b.tx_count) >= DEPTH))
		else $error("tx ready b wrong for fill level");
	a_rx_empty: assert property (disable iff (reset)
		!$past(reset) && $past(stat_a.rx_count) == 0 |-> receive_ready_a_n)
		else $error("rx ready active while empty");
	a_rx_deep: assert property (disable iff (reset)
		!$past(reset) && $past(stat_a.rx_count) >= 14 |-> !receive_ready_a_n)
		else $error("rx ready idle above every trigger");

	// Bus drive only answers a synchronised read strobe
	a_read_answer: assert property (disable iff (reset)
		$rose(data_oe) |-> !read_strobe_n && !$past(read_strobe_n, 3))
		else $error("data bus driven without read strobe");
	a_oe_release: assert property (disable iff (reset)
		read_strobe_n [*5] |-> !data_oe)
		else $error("data bus still driven after strobe");
	a_irq_drive: assert property (disable iff (reset)
		channel_a_interrupt_oe |-> channel_a_interrupt)
		else $error("interrupt pin driven with nothing pending");
endmodule

// ---- verif/host_bus_model.sv ----
// Host bus master model for the strobe register port
`timescale 1ns/100ps
module host_bus_model (
	// Clock
	input wire logic clk,
	// Bus pins toward the device
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic chip_select_a_n,
	output logic chip_select_b_n,
	output logic [2:0] addr,
	output logic [7:0] data_in,
	// Read data from the device
	input wire logic [7:0] data_out
);
	// Idle bus at time zero
	initial begin
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		chip_select_a_n = 1'b1;
		chip_select_b_n = 1'b1;
		addr = 3'h0;
		data_in = 8'h5A;
	end

	// Setup two cycles, strobe low four, recover four; pins are synchronised
	task automatic cycle(input logic rd, input logic [1:0] sel_n,
		input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		chip_select_a_n <= sel_n[0];
		chip_select_b_n <= sel_n[1];
		addr <= a;
		data_in <= rd ? ~data_in : d;
		repeat (2) @(posedge clk);
		if (rd)
			read_strobe_n <= 1'b0;
		else
			write_strobe_n <= 1'b0;
		repeat (4) @(posedge clk);
		q = data_out;
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		chip_select_a_n <= 1'b1;
		chip_select_b_n <= 1'b1;
		// Released bus shows the inverse, not a stale copy
		data_in <= ~data_in;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ---- verif/uart_status_pins_tb.sv ----
// Self-checking bench for the dual-channel status pin logic
`timescale 1ns/100ps
module uart_status_pins_tb;
	localparam int DEPTH = 16;
	localparam int LIMIT = 4000;
	localparam logic [1:0] SEL_A = 2'h2;
	localparam logic [1:0] SEL_B = 2'h1;
	localparam logic [1:0] SEL_AB = 2'h0;
	localparam logic [1:0] SEL_NONE = 2'h3;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic rs_n, ws_n, cs_a_n, cs_b_n, oe;
	logic [2:0] addr;
	logic [7:0] din, dout, q;
	pin_logic_pkg::chan_stat_s stat_a = '0;
	pin_logic_pkg::chan_stat_s stat_b = '0;
	logic mf_a, rr_a_n, tr_a_n, irq_a, irq_a_oe, ser_a;
	logic mf_b, rr_b_n, tr_b_n, irq_b, irq_b_oe, ser_b;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	uart_status_pins #(.DEPTH(DEPTH)) uut (
		.clk(clk), .reset(reset), .read_strobe_n(rs_n),
		.write_strobe_n(ws_n), .chip_select_a_n(cs_a_n),
		.chip_select_b_n(cs_b_n), .addr(addr), .data_in(din),
		.data_out(dout), .data_oe(oe), .stat_a(stat_a), .stat_b(stat_b),
		.multi_function_out_a(mf_a), .receive_ready_a_n(rr_a_n),
		.transmit_ready_a_n(tr_a_n), .channel_a_interrupt(irq_a),
		.channel_a_interrupt_oe(irq_a_oe), .serial_enable_a(ser_a),
		.multi_function_out_b(mf_b), .receive_ready_b_n(rr_b_n),
		.transmit_ready_b_n(tr_b_n), .channel_b_interrupt(irq_b),
		.channel_b_interrupt_oe(irq_b_oe), .serial_enable_b(ser_b));

	host_bus_model host (.clk(clk), .read_strobe_n(rs_n),
		.write_strobe_n(ws_n), .chip_select_a_n(cs_a_n),
		.chip_select_b_n(cs_b_n), .addr(addr), .data_in(din),
		.data_out(dout));

	// Compare a register byte
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t byte %h want %h", $time, got, exp);
		end
	endtask

	// Compare a pin level
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t pin %b want %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] s, input logic [2:0] a,
		input logic [7:0] d);
		host.cycle(1'b0, s, a, d, q);
	endtask

	task automatic rd(input logic [1:0] s, input logic [2:0] a);
		host.cycle(1'b1, s, a, 8'h00, q);
	endtask

	// Pins lag stat by one cycle, interrupts by three; one edge spare
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard well above the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		settle();
		for (int a = 1; a < 8; a++) begin
			rd(SEL_A, 3'(a));
			// Events hold the tx ready rise seen at release
			chk8(q, (a == 5) ? 8'h02 : 8'h00);
		end
		chk1(mf_a, 1'b1);
		chk1(ser_a, 1'b1);
		chk1(ser_b, 1'b1);
		$display("test reset values done");
		wr(SEL_A, pin_logic_pkg::ADDR_MCR, 8'h08);
		chk1(mf_a, 1'b0);
		chk1(mf_b, 1'b1);
		wr(SEL_A, pin_logic_pkg::ADDR_AFR, 8'h02);
		stat_a.baud16 <= 1'b1;
		settle();
		chk1(mf_a, 1'b1);
		stat_a.baud16 <= 1'b0;
		settle();
		chk1(mf_a, 1'b0);
		wr(SEL_A, pin_logic_pkg::ADDR_AFR, 8'h04);
		chk1(mf_a, 1'b1);
		stat_a.rx_count <= 5'h01;
		settle();
		chk1(mf_a, 1'b0);
		chk1(rr_a_n, 1'b0);
		chk1(rr_b_n, 1'b1);
		wr(SEL_A, pin_logic_pkg::ADDR_AFR, 8'h06);
		chk1(mf_a, 1'b1);
		wr(SEL_A, pin_logic_pkg::ADDR_AFR, 8'h00);
		$display("test multi-function done");
		// Mode 1 with the deepest trigger
		wr(SEL_A, pin_logic_pkg::ADDR_DMA, 8'h07);
		chk1(rr_a_n, 1'b1);
		stat_a.rx_count <= 5'h0D;
		settle();
		chk1(rr_a_n, 1'b1);
		stat_a.rx_count <= 5'h0E;
		settle();
		chk1(rr_a_n, 1'b0);
		// Middle triggers: four, then eight
		wr(SEL_A, pin_logic_pkg::ADDR_DMA, 8'h03);
		stat_a.rx_count <= 5'h03;
		settle();
		chk1(rr_a_n, 1'b1);
		stat_a.rx_count <= 5'h04;
		settle();
		chk1(rr_a_n, 1'b0);
		wr(SEL_A, pin_logic_pkg::ADDR_DMA, 8'h05);
		chk1(rr_a_n, 1'b1);
		rd(SEL_A, pin_logic_pkg::ADDR_STATUS);
		chk8(q, 8'h02);
		stat_a.rx_count <= 5'h08;
		settle();
		chk1(rr_a_n, 1'b0);
		wr(SEL_A, pin_logic_pkg::ADDR_DMA, 8'h00);
		stat_a.rx_count <= 5'h00;
		stat_a.tx_count <= 5'h0F;
		settle();
		chk1(rr_a_n, 1'b1);
		chk1(tr_a_n, 1'b0);
		stat_a.tx_count <= 5'h10;
		stat_a.rx_count <= 5'h01;
		settle();
		chk1(tr_a_n, 1'b1);
		chk1(tr_b_n, 1'b0);
		rd(SEL_A, pin_logic_pkg::ADDR_STATUS);
		chk8(q, 8'h05);
		chk1(oe, 1'b0);
		$display("test ready pins done");
		// Clear stale events, then raise rx ready
		stat_a.rx_count <= 5'h00;
		wr(SEL_A, pin_logic_pkg::ADDR_IER, 8'h01);
		rd(SEL_A, pin_logic_pkg::ADDR_EVENTS);
		stat_a.rx_count <= 5'h01;
		settle();
		chk1(irq_a, 1'b1);
		chk1(irq_a_oe, 1'b1);
		rd(SEL_A, pin_logic_pkg::ADDR_EVENTS);
		chk8(q, 8'h01);
		chk1(irq_a, 1'b0);
		// Line event masked, then pending with the pin enable off
		wr(SEL_A, pin_logic_pkg::ADDR_IER, 8'h00);
		stat_a.line_event <= 1'b1;
		@(posedge clk);
		stat_a.line_event <= 1'b0;
		settle();
		chk1(irq_a, 1'b0);
		wr(SEL_A, pin_logic_pkg::ADDR_MCR, 8'h00);
		wr(SEL_A, pin_logic_pkg::ADDR_IER, 8'h04);
		chk1(irq_a, 1'b1);
		chk1(irq_a_oe, 1'b0);
		chk1(mf_a, 1'b1);
		rd(SEL_A, pin_logic_pkg::ADDR_EVENTS);
		chk8(q, 8'h04);
		// Channel B still holds its tx ready event from reset
		wr(SEL_B, pin_logic_pkg::ADDR_IER, 8'h02);
		chk1(irq_b, 1'b1);
		chk1(irq_b_oe, 1'b0);
		chk1(irq_a, 1'b0);
		wr(SEL_B, pin_logic_pkg::ADDR_MCR, 8'h08);
		chk1(irq_b_oe, 1'b1);
		chk1(mf_b, 1'b0);
		chk1(irq_a_oe, 1'b0);
		$display("test interrupts done");
		wr(SEL_NONE, pin_logic_pkg::ADDR_AFR, 8'h02);
		wr(SEL_AB, pin_logic_pkg::ADDR_DMA, 8'h01);
		rd(SEL_B, pin_logic_pkg::ADDR_DMA);
		chk8(q, 8'h01);
		rd(SEL_A, pin_logic_pkg::ADDR_AFR);
		chk8(q, 8'h00);
		$display("test bus writes done");
		// Second reset in mid-run
		reset <= 1'b1;
		repeat (5) @(posedge clk);
		chk1(ser_a, 1'b0);
		chk1(ser_b, 1'b0);
		chk1(irq_b, 1'b0);
		chk1(irq_b_oe, 1'b0);
		chk1(tr_a_n, 1'b1);
		reset <= 1'b0;
		settle();
		rd(SEL_B, pin_logic_pkg::ADDR_DMA);
		chk8(q, 8'h00);
		chk1(mf_b, 1'b1);
		chk1(irq_b, 1'b0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule

bind uart_status_pins uart_status_pins_chk #(.DEPTH(DEPTH)) chk (
	.clk(clk), .reset(reset), .read_strobe_n(read_strobe_n),
	.data_oe(data_oe), .stat_a(stat_a), .stat_b(stat_b),
	.multi_function_out_a(multi_function_out_a),
	.receive_ready_a_n(receive_ready_a_n),
	.transmit_ready_a_n(transmit_ready_a_n),
	.transmit_ready_b_n(transmit_ready_b_n),
	.channel_a_interrupt(channel_a_interrupt),
	.channel_a_interrupt_oe(channel_a_interrupt_oe),
	.serial_enable_a(serial_enable_a));
